// File: hdl/trap_monitor_pkg.sv
package trap_monitor_pkg;

  // Register offsets in the power management IO block.
  localparam logic [7:0] TRAP_EVENT_STATUS_OFS       = 8'hA8;
  localparam logic [7:0] TRAP_INTERRUPT_ENABLE_OFS   = 8'hAC;
  localparam logic [7:0] TRAP_IDLE_RELOAD_ENABLE_OFS = 8'hB0;

  localparam logic [19:0] TRAP_EVENT_STATUS_RST       = 20'h00000;
  localparam logic [19:0] TRAP_INTERRUPT_ENABLE_RST   = 20'h00000;
  localparam logic [21:0] TRAP_IDLE_RELOAD_ENABLE_RST = 22'h000000;

  localparam int TRAP_BITS        = 20;
  localparam int RELOAD_BITS      = 22;
  localparam int EXT_SMI_RLEN_BIT = 20;
  localparam int BUS_MASTER_RLEN_BIT = 21;
  localparam int DRIVE_SELECT_BIT = 4;

  localparam int PRI_MASTER_BIT   = 0;
  localparam int PRI_SLAVE_BIT    = 1;
  localparam int SEC_MASTER_BIT   = 2;
  localparam int SEC_SLAVE_BIT    = 3;
  localparam int FLOPPY_BIT       = 4;
  localparam int PARALLEL_BIT     = 5;
  localparam int SERIAL_A_BIT     = 6;
  localparam int SERIAL_B_BIT     = 7;
  localparam int AUDIO_BIT        = 8;
  localparam int VIDEO_BIT        = 9;
  localparam int KEYBOARD_BIT     = 10;
  localparam int CARD_SLOT1_BIT   = 11;
  localparam int CARD_SLOT2_BIT   = 12;
  localparam int USB_BIT          = 13;
  localparam int IO_MON1_BIT      = 14;
  localparam int MEM_MON1_BIT     = 18;

  localparam logic [15:0] PRI_CMD_PORT   = 16'h01F0;
  localparam logic [15:0] PRI_CTL_PORT   = 16'h03F6;
  localparam logic [15:0] PRI_HEAD_PORT  = 16'h01F6;
  localparam logic [15:0] SEC_CMD_PORT   = 16'h0170;
  localparam logic [15:0] SEC_CTL_PORT   = 16'h0376;
  localparam logic [15:0] SEC_HEAD_PORT  = 16'h0176;
  localparam logic [15:0] FDD_PRI_PORT   = 16'h03F0;
  localparam logic [15:0] FDD_SEC_PORT   = 16'h0370;
  localparam logic [15:0] LPT1_PORT      = 16'h0378;
  localparam logic [15:0] LPT2_PORT      = 16'h0278;
  localparam logic [15:0] LPT3_PORT      = 16'h03BC;
  localparam logic [15:0] VGA_IO_LO      = 16'h03B0;
  localparam logic [15:0] VGA_IO_HI      = 16'h03DF;
  localparam logic [31:0] VGA_MEM_LO     = 32'h000A0000;
  localparam logic [31:0] VGA_MEM_HI     = 32'h000BFFFF;
  localparam logic [15:0] KBD_DATA_PORT  = 16'h0060;
  localparam logic [15:0] KBD_CMD_PORT   = 16'h0064;
  localparam logic [15:0] NATIVE_CTL_OFS = 16'h0002;
  localparam logic [15:0] HEAD_REG_OFS   = 16'h0006;

  // Inactivity timer clock source periods in milliseconds.
  localparam real   CLOCK_PERIOD_NS = 5.0;
  localparam real   MS_NS           = 1000000.0;
  localparam int    MS_CYCLES       = int'(MS_NS / CLOCK_PERIOD_NS);
  localparam logic [17:0] SRC0_MS   = 18'h00040;
  localparam logic [17:0] SRC1_MS   = 18'h003E8;
  localparam logic [17:0] SRC2_MS   = 18'h03E80;
  localparam logic [17:0] SRC3_MS   = 18'h3E800;

  // One completed host bus cycle.
  typedef struct packed {
    logic        done;
    logic        is_io;
    logic        write;
    logic [31:0] addr;
    logic [7:0]  data;
  } host_cycle_s;

  // Native mode decode bases of one drive channel.
  typedef struct packed {
    logic        native;
    logic [15:0] cmd_base;
    logic [15:0] ctl_base;
  } drive_channel_s;

endpackage

// File: hdl/legacy_decode.sv
`timescale 1ns/100ps
module legacy_decode (
  input  wire logic                            sys_clk,
  input  wire logic                            reset,
  input  wire trap_monitor_pkg::host_cycle_s   cycle,
  input  wire trap_monitor_pkg::drive_channel_s pri_chan,
  input  wire trap_monitor_pkg::drive_channel_s sec_chan,
  output logic [12:0]                          fixed_hit,
  output logic                                 primary_drive_head_reg,
  output logic                                 secondary_drive_head_reg
);

  wire logic [15:0] io_addr = cycle.addr[15:0];
  wire logic        io_cyc  = cycle.done & cycle.is_io;
  wire logic        mem_cyc = cycle.done & ~cycle.is_io;

  // Native channels decode at their programmed bases.
  wire logic [15:0] pri_cmd = pri_chan.native ? pri_chan.cmd_base : trap_monitor_pkg::PRI_CMD_PORT;
  wire logic [15:0] pri_ctl = pri_chan.native ? 16'(pri_chan.ctl_base + trap_monitor_pkg::NATIVE_CTL_OFS)
                                              : trap_monitor_pkg::PRI_CTL_PORT;
  wire logic [15:0] sec_cmd = sec_chan.native ? sec_chan.cmd_base : trap_monitor_pkg::SEC_CMD_PORT;
  wire logic [15:0] sec_ctl = sec_chan.native ? 16'(sec_chan.ctl_base + trap_monitor_pkg::NATIVE_CTL_OFS)
                                              : trap_monitor_pkg::SEC_CTL_PORT;

  wire logic pri_hit = io_cyc & ((io_addr[15:3] == pri_cmd[15:3]) | (io_addr == pri_ctl));
  wire logic sec_hit = io_cyc & ((io_addr[15:3] == sec_cmd[15:3]) | (io_addr == sec_ctl));
  wire logic pri_head_wr = io_cyc & cycle.write
                         & (io_addr == 16'(pri_cmd + trap_monitor_pkg::HEAD_REG_OFS));
  wire logic sec_head_wr = io_cyc & cycle.write
                         & (io_addr == 16'(sec_cmd + trap_monitor_pkg::HEAD_REG_OFS));

  // Offset 6 of each floppy block belongs to the drive channel.
  wire logic fdd_blk = (io_addr[15:3] == trap_monitor_pkg::FDD_PRI_PORT[15:3])
                     | (io_addr[15:3] == trap_monitor_pkg::FDD_SEC_PORT[15:3]);
  wire logic floppy  = io_cyc & fdd_blk & (io_addr[2:0] != 3'h6);

  wire logic parallel = io_cyc & ((io_addr[15:3] == trap_monitor_pkg::LPT1_PORT[15:3])
                                | (io_addr[15:3] == trap_monitor_pkg::LPT2_PORT[15:3])
                                | (io_addr[15:2] == trap_monitor_pkg::LPT3_PORT[15:2]));

  wire logic video = (io_cyc & (io_addr >= trap_monitor_pkg::VGA_IO_LO) & (io_addr <= trap_monitor_pkg::VGA_IO_HI))
                   | (mem_cyc & (cycle.addr >= trap_monitor_pkg::VGA_MEM_LO)
                              & (cycle.addr <= trap_monitor_pkg::VGA_MEM_HI));

  wire logic keyboard = io_cyc & ((io_addr == trap_monitor_pkg::KBD_DATA_PORT)
                                | (io_addr == trap_monitor_pkg::KBD_CMD_PORT));

  // The select bit in force before this cycle decides master or slave.
  assign fixed_hit[trap_monitor_pkg::PRI_MASTER_BIT] = pri_hit & ~primary_drive_head_reg;
  assign fixed_hit[trap_monitor_pkg::PRI_SLAVE_BIT]  = pri_hit &  primary_drive_head_reg;
  assign fixed_hit[trap_monitor_pkg::SEC_MASTER_BIT] = sec_hit & ~secondary_drive_head_reg;
  assign fixed_hit[trap_monitor_pkg::SEC_SLAVE_BIT]  = sec_hit &  secondary_drive_head_reg;
  assign fixed_hit[trap_monitor_pkg::FLOPPY_BIT]     = floppy;
  assign fixed_hit[trap_monitor_pkg::PARALLEL_BIT]   = parallel;
  assign fixed_hit[8:6]                              = 3'h0;
  assign fixed_hit[trap_monitor_pkg::VIDEO_BIT]      = video;
  assign fixed_hit[trap_monitor_pkg::KEYBOARD_BIT]   = keyboard;
  assign fixed_hit[12:11]                            = 2'h0;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      primary_drive_head_reg   <= 1'b0;
      secondary_drive_head_reg <= 1'b0;
    end else begin
      if (pri_head_wr) begin
        primary_drive_head_reg <= cycle.data[trap_monitor_pkg::DRIVE_SELECT_BIT];
      end
      if (sec_head_wr) begin
        secondary_drive_head_reg <= cycle.data[trap_monitor_pkg::DRIVE_SELECT_BIT];
      end
    end
  end

endmodule

// File: hdl/idle_timer.sv
`timescale 1ns/100ps
module idle_timer #(
  parameter int MS_CYCLES = trap_monitor_pkg::MS_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       reload,
  input  wire logic       hold,
  input  wire logic [7:0] reload_value,
  input  wire logic [1:0] clksrc,
  output logic [7:0]      idle_timer_count,
  output logic            idle_expired
);

  logic [31:0] ms_div;
  logic [17:0] ms_count;

  wire logic        ms_tick = (ms_div == 32'(MS_CYCLES - 1));
  wire logic [17:0] src_ms  = (clksrc == 2'h0) ? trap_monitor_pkg::SRC0_MS :
                              (clksrc == 2'h1) ? trap_monitor_pkg::SRC1_MS :
                              (clksrc == 2'h2) ? trap_monitor_pkg::SRC2_MS : trap_monitor_pkg::SRC3_MS;
  wire logic        src_tick = ms_tick & (ms_count == 18'(src_ms - 18'h00001));
  wire logic        restart  = reload | hold;

  // The prescaler restarts on reload so every reload gets a full first period.
  always_ff @(posedge sys_clk) begin
    if (reset | restart | ms_tick) begin
      ms_div <= 32'h00000000;
    end else begin
      ms_div <= ms_div + 32'h00000001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset | restart | src_tick) begin
      ms_count <= 18'h00000;
    end else if (ms_tick) begin
      ms_count <= ms_count + 18'h00001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      idle_timer_count <= 8'h00;
    end else if (restart) begin
      idle_timer_count <= reload_value;
    end else if (src_tick && idle_timer_count != 8'h00) begin
      idle_timer_count <= idle_timer_count - 8'h01;
    end
  end

  assign idle_expired = (idle_timer_count == 8'h00);

endmodule

// File: hdl/legacy_access_trap_monitor.sv
// Operation
// - Primary drive access sets bit 0 for master, bit 1 for slave.
// - Drive/head register bit 4 picks master (0) or slave (1).
// - Native primary channel decodes at programmed bases, not legacy ports.
// - Secondary drive access sets bits 2 and 3 per its drive select.
// - Native secondary channel decodes at programmed bases.
// - Floppy port access sets bit 4.
// - Any of three parallel port ranges sets bit 5.
// - Video IO range or legacy video memory sets bit 9.
// - Keyboard data or command port access sets bit 10.
// - Serial, audio and card slot decode hits set bits 6-8, 11, 12.
// - IO monitors set bits 14-17; memory monitors set bits 18, 19.
// - Completed USB transfer sets bit 13.
// - Twenty sticky status bits, cleared by writing one; upper bits zero.
// - Enabled pending status raises SMI or ACPI interrupt per route select.
// - Any enabled pending status asserts the trap event flag.
// - Reload-enabled trap events reload the inactivity timer.
// - External SMI status reloads and holds timer while set, if enabled.
// - Bus master request assertion reloads timer when enabled.
// - Reload loads the 8-bit reload value; timer counts down from it.
`timescale 1ns/100ps
module legacy_access_trap_monitor #(
  parameter int MS_CYCLES   = trap_monitor_pkg::MS_CYCLES,
  parameter int BM_REQ_BITS = 4
) (
  input  wire logic                             sys_clk,
  input  wire logic                             reset,
  input  wire trap_monitor_pkg::host_cycle_s    cycle,
  input  wire trap_monitor_pkg::drive_channel_s pri_chan,
  input  wire trap_monitor_pkg::drive_channel_s sec_chan,
  input  wire logic                             serial_a_hit,
  input  wire logic                             serial_b_hit,
  input  wire logic                             audio_hit,
  input  wire logic                             card_slot1_hit,
  input  wire logic                             card_slot2_hit,
  input  wire logic [3:0]                       io_range_mon_hit,
  input  wire logic [1:0]                       mem_range_mon_hit,
  input  wire logic                             usb_transfer_done,
  input  wire logic                             external_smi_status,
  input  wire logic [BM_REQ_BITS-1:0]           bus_master_req,
  input  wire logic                             acpi_interrupt_route_select,
  input  wire logic [7:0]                       idle_reload_value,
  input  wire logic                             idle_reload_write,
  input  wire logic [1:0]                       idle_clksrc,
  input  wire logic                             reg_wr,
  input  wire logic                             reg_rd,
  input  wire logic [7:0]                       reg_addr,
  input  wire logic [31:0]                      reg_wdata,
  output logic [31:0]                           reg_rdata,
  output logic                                  smi_req,
  output logic                                  sci_req,
  output logic                                  trap_event_flag,
  output logic [7:0]                            idle_timer_count,
  output logic                                  idle_expired,
  output logic                                  primary_drive_head_reg,
  output logic                                  secondary_drive_head_reg
);

  localparam int NT = trap_monitor_pkg::TRAP_BITS;
  localparam int NR = trap_monitor_pkg::RELOAD_BITS;

  logic [NT-1:0] trap_event_status;
  logic [NT-1:0] trap_interrupt_enable;
  logic [NR-1:0] trap_idle_reload_enable;
  logic          ext_smi_prev;
  logic          bm_req_prev;
  logic [12:0]   fixed_hit;

  legacy_decode u_decode (
    .sys_clk                  (sys_clk),
    .reset                    (reset),
    .cycle                    (cycle),
    .pri_chan                 (pri_chan),
    .sec_chan                 (sec_chan),
    .fixed_hit                (fixed_hit),
    .primary_drive_head_reg   (primary_drive_head_reg),
    .secondary_drive_head_reg (secondary_drive_head_reg)
  );

  // External decoder hits count only with a completed host cycle.
  wire logic done = cycle.done;

  wire logic [NT-1:0] trap_hit;
  assign trap_hit[5:0]  = fixed_hit[5:0];
  assign trap_hit[trap_monitor_pkg::SERIAL_A_BIT]   = done & serial_a_hit;
  assign trap_hit[trap_monitor_pkg::SERIAL_B_BIT]   = done & serial_b_hit;
  assign trap_hit[trap_monitor_pkg::AUDIO_BIT]      = done & audio_hit;
  assign trap_hit[10:9] = fixed_hit[10:9];
  assign trap_hit[trap_monitor_pkg::CARD_SLOT1_BIT] = done & card_slot1_hit;
  assign trap_hit[trap_monitor_pkg::CARD_SLOT2_BIT] = done & card_slot2_hit;
  // USB activity is flagged at the end of the transfer, not at its start.
  assign trap_hit[trap_monitor_pkg::USB_BIT]        = usb_transfer_done;
  assign trap_hit[17:14] = {4{done}} & io_range_mon_hit;
  assign trap_hit[19:18] = {2{done}} & mem_range_mon_hit;

  wire logic sel_status = (reg_addr == trap_monitor_pkg::TRAP_EVENT_STATUS_OFS);
  wire logic sel_enable = (reg_addr == trap_monitor_pkg::TRAP_INTERRUPT_ENABLE_OFS);
  wire logic sel_reload = (reg_addr == trap_monitor_pkg::TRAP_IDLE_RELOAD_ENABLE_OFS);

  wire logic [NT-1:0] status_clear = (reg_wr & sel_status) ? reg_wdata[NT-1:0] : '0;

  // A trap in the same cycle as its clear keeps the bit set.
  wire logic [NT-1:0] next_status = (trap_event_status & ~status_clear) | trap_hit;

  wire logic [31:0] next_rdata = sel_status ? {12'h000, trap_event_status}      :
                                 sel_enable ? {12'h000, trap_interrupt_enable}  :
                                 sel_reload ? {10'h000, trap_idle_reload_enable} : 32'h00000000;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      trap_event_status <= trap_monitor_pkg::TRAP_EVENT_STATUS_RST;
    end else begin
      trap_event_status <= next_status;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      trap_interrupt_enable   <= trap_monitor_pkg::TRAP_INTERRUPT_ENABLE_RST;
      trap_idle_reload_enable <= trap_monitor_pkg::TRAP_IDLE_RELOAD_ENABLE_RST;
    end else if (reg_wr) begin
      if (sel_enable) begin
        trap_interrupt_enable <= reg_wdata[NT-1:0];
      end
      if (sel_reload) begin
        trap_idle_reload_enable <= reg_wdata[NR-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  wire logic pending = |(trap_event_status & trap_interrupt_enable);
  assign trap_event_flag = pending;
  assign smi_req         = pending & ~acpi_interrupt_route_select;
  assign sci_req         = pending &  acpi_interrupt_route_select;

  wire logic bm_req_any = |bus_master_req;
  wire logic external_smi_idle_reload = trap_idle_reload_enable[trap_monitor_pkg::EXT_SMI_RLEN_BIT];
  wire logic bus_master_idle_reload   = trap_idle_reload_enable[trap_monitor_pkg::BUS_MASTER_RLEN_BIT];

  wire logic trap_reload = |(trap_hit & trap_idle_reload_enable[NT-1:0]);
  wire logic ext_reload  = external_smi_idle_reload & external_smi_status & ~ext_smi_prev;
  wire logic ext_hold    = external_smi_idle_reload & external_smi_status;
  wire logic bm_reload   = bus_master_idle_reload & bm_req_any & ~bm_req_prev;
  wire logic any_reload  = trap_reload | ext_reload | bm_reload | idle_reload_write;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ext_smi_prev <= 1'b0;
      bm_req_prev  <= 1'b0;
    end else begin
      ext_smi_prev <= external_smi_status;
      bm_req_prev  <= bm_req_any;
    end
  end

  idle_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_idle_timer (
    .sys_clk          (sys_clk),
    .reset            (reset),
    .reload           (any_reload),
    .hold             (ext_hold),
    .reload_value     (idle_reload_value),
    .clksrc           (idle_clksrc),
    .idle_timer_count (idle_timer_count),
    .idle_expired     (idle_expired)
  );

endmodule

// File: bench/trap_monitor_monitor.sv
`timescale 1ns/100ps
module trap_monitor_check #(
  parameter int BM_REQ_BITS = 4
) (
  input wire logic                          sys_clk,
  input wire logic                          reset,
  input wire trap_monitor_pkg::host_cycle_s cycle,
  input wire logic                          usb_transfer_done,
  input wire logic                          external_smi_status,
  input wire logic [BM_REQ_BITS-1:0]        bus_master_req,
  input wire logic                          acpi_interrupt_route_select,
  input wire logic [7:0]                    idle_reload_value,
  input wire logic                          idle_reload_write,
  input wire logic                          reg_wr,
  input wire logic                          reg_rd,
  input wire logic [7:0]                    reg_addr,
  input wire logic [31:0]                   reg_wdata,
  input wire logic [31:0]                   reg_rdata,
  input wire logic                          smi_req,
  input wire logic                          sci_req,
  input wire logic                          trap_event_flag,
  input wire logic [7:0]                    idle_timer_count
);
  logic [21:0] rlen;
  wire         rl_wr  = reg_wr && reg_addr == trap_monitor_pkg::TRAP_IDLE_RELOAD_ENABLE_OFS;
  wire         mapped = reg_addr inside {8'hA8, 8'hAC, 8'hB0};
  always_ff @(posedge sys_clk) begin
    rlen <= reset ? '0 : (rl_wr ? reg_wdata[21:0] : rlen);
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  route_smi_a: assert property (smi_req |-> !acpi_interrupt_route_select && trap_event_flag)
    else $error("smi route");
  route_sci_a: assert property (sci_req |-> acpi_interrupt_route_select && trap_event_flag)
    else $error("sci route");
  flag_route_a: assert property (trap_event_flag |-> smi_req || sci_req)
    else $error("flag route");
  flag_sticky_a: assert property (trap_event_flag && !reg_wr |=> trap_event_flag)
    else $error("flag drop");
  flag_cause_a: assert property ($rose(trap_event_flag) |-> $past(cycle.done || reg_wr || usb_transfer_done))
    else $error("flag cause");
  smi_hold_a: assert property (rlen[20] && external_smi_status |=> idle_timer_count == $past(idle_reload_value))
    else $error("smi hold");
  bm_reload_a: assert property (rlen[21] && $rose(|bus_master_req) |=> idle_timer_count == $past(idle_reload_value))
    else $error("bm reload");
  kbd_reload_a: assert property (cycle.done && cycle.is_io && cycle.addr == 32'h60 && rlen[10]
    |=> idle_timer_count == $past(idle_reload_value)) else $error("trap reload");
  sw_reload_a: assert property (idle_reload_write |=> idle_timer_count == $past(idle_reload_value))
    else $error("sw reload");
  unmapped_zero_a: assert property (reg_rd && !mapped |=> reg_rdata == 32'h0)
    else $error("unmapped rd");
  reserved_zero_a: assert property (reg_rd && reg_addr == 8'hA8 |=> reg_rdata[31:20] == 12'h000)
    else $error("reserved rd");
  cover property (smi_req);
  cover property (sci_req);
  cover property (rlen[20] && external_smi_status ##1 external_smi_status);
endmodule
bind legacy_access_trap_monitor trap_monitor_check #(.BM_REQ_BITS(BM_REQ_BITS)) i_trap_monitor_check (
  .sys_clk(sys_clk), .reset(reset), .cycle(cycle), .usb_transfer_done(usb_transfer_done),
  .external_smi_status(external_smi_status), .bus_master_req(bus_master_req),
  .acpi_interrupt_route_select(acpi_interrupt_route_select), .idle_reload_value(idle_reload_value),
  .idle_reload_write(idle_reload_write), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .smi_req(smi_req), .sci_req(sci_req),
  .trap_event_flag(trap_event_flag), .idle_timer_count(idle_timer_count));

// File: bench/host_model.sv
`timescale 1ns/100ps
module host_model (
  input wire logic                     sys_clk,
  output trap_monitor_pkg::host_cycle_s cycle
);
  initial cycle = '0;
  // Idle lines show the inverse of the last value.
  task automatic access(input logic io, input logic w, input logic [31:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    cycle <= '{done: 1'b1, is_io: io, write: w, addr: a, data: d};
    @(negedge sys_clk);
    cycle <= '{done: 1'b0, is_io: !io, write: !w, addr: ~a, data: ~d};
  endtask
endmodule

// File: bench/tb.sv
`timescale 1ns/100ps
module tb;
  logic                             sys_clk, reset, usb_transfer_done, external_smi_status, rd_pending;
  logic                             acpi_interrupt_route_select, idle_reload_write, reg_wr, reg_rd;
  logic                             smi_req, sci_req, trap_event_flag, idle_expired, pri_sel, sec_sel;
  trap_monitor_pkg::host_cycle_s    cycle;
  trap_monitor_pkg::drive_channel_s pri_chan, sec_chan;
  logic [10:0]                      ext_hit;
  logic [3:0]                       bus_master_req;
  logic [1:0]                       idle_clksrc;
  logic [7:0]                       idle_reload_value, reg_addr, idle_timer_count, v;
  logic [31:0]                      reg_wdata, reg_rdata, lfsr_state, exp_q[$];
  int                               mismatches, num_checks, cycles;
  localparam logic [31:0] TA [23] = '{32'h1F0, 32'h1F7, 32'h3F6, 32'h170, 32'h376, 32'h3F0, 32'h3F5, 32'h3F7,
    32'h370, 32'h377, 32'h378, 32'h27F, 32'h3BC, 32'h3BF, 32'h3B0, 32'h3DF, 32'hA0000, 32'hBFFFF, 32'h60,
    32'h64, 32'h3E0, 32'hC0000, 32'h61};
  localparam logic [19:0] TE [23] = '{20'h1, 20'h1, 20'h1, 20'h4, 20'h4, 20'h10, 20'h10, 20'h10, 20'h10,
    20'h10, 20'h20, 20'h20, 20'h220, 20'h220, 20'h200, 20'h200, 20'h200, 20'h200, 20'h400, 20'h400, 20'h0,
    20'h0, 20'h0};
  legacy_access_trap_monitor #(.MS_CYCLES(4)) i_legacy_access_trap_monitor (
    .sys_clk(sys_clk), .reset(reset), .cycle(cycle), .pri_chan(pri_chan), .sec_chan(sec_chan),
    .serial_a_hit(ext_hit[0]), .serial_b_hit(ext_hit[1]), .audio_hit(ext_hit[2]), .card_slot1_hit(ext_hit[3]),
    .card_slot2_hit(ext_hit[4]), .io_range_mon_hit(ext_hit[8:5]), .mem_range_mon_hit(ext_hit[10:9]),
    .usb_transfer_done(usb_transfer_done), .external_smi_status(external_smi_status),
    .bus_master_req(bus_master_req), .acpi_interrupt_route_select(acpi_interrupt_route_select),
    .idle_reload_value(idle_reload_value), .idle_reload_write(idle_reload_write), .idle_clksrc(idle_clksrc),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .smi_req(smi_req), .sci_req(sci_req), .trap_event_flag(trap_event_flag), .idle_timer_count(idle_timer_count),
    .idle_expired(idle_expired), .primary_drive_head_reg(pri_sel), .secondary_drive_head_reg(sec_sel));
  host_model host (.sys_clk(sys_clk), .cycle(cycle));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    rd_pending <= reg_rd;
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      close_out();
    end
  end
  always @(negedge sys_clk) if (rd_pending) check(reg_rdata, exp_q.pop_front());
  function automatic void rnd();
    lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(negedge sys_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    exp_q.push_back(e);
    @(negedge sys_clk);
    reg_rd = 1'b0;
  endtask
  task automatic trap(input logic io, input logic w, input logic [31:0] a, input logic [7:0] d, input logic [19:0] e);
    host.access(io, w, a, d);
    check(32'(smi_req), 32'(e != 20'h0));
    check(32'(trap_event_flag), 32'(e != 20'h0));
    rd(8'hA8, {12'h000, e});
    wr(8'hA8, 32'hFFFFFFFF);
  endtask
  initial begin
    reset = 1'b1;
    {usb_transfer_done, external_smi_status, acpi_interrupt_route_select, idle_reload_write} = 4'h0;
    {reg_wr, reg_rd, reg_addr, reg_wdata, ext_hit, bus_master_req, idle_clksrc} = '0;
    {pri_chan, sec_chan, idle_reload_value, rd_pending, mismatches, num_checks, cycles} = '0;
    lfsr_state = 32'h9760;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    check(32'(idle_expired), 32'h1);
    rd(8'hA8, 32'h0);
    rd(8'hAC, 32'h0);
    rd(8'hB0, 32'h0);
    rnd();
    wr(8'hAC, lfsr_state);
    rd(8'hAC, {12'h000, lfsr_state[19:0]});
    rnd();
    wr(8'hB0, lfsr_state);
    rd(8'hB0, {10'h000, lfsr_state[21:0]});
    wr(8'hB4, 32'hFFFFFFFF);
    rd(8'hB4, 32'h0);
    wr(8'hAC, 32'hFFFFFFFF);
    wr(8'hB0, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 23; i++) trap(TA[i] < 32'h10000, 1'b0, TA[i], 8'h00, TE[i]);
    trap(1'b1, 1'b1, 32'h1F6, 8'h10, 20'h1);
    check(32'(pri_sel), 32'h1);
    trap(1'b1, 1'b0, 32'h3F6, 8'h00, 20'h2);
    trap(1'b1, 1'b1, 32'h176, 8'h10, 20'h4);
    check(32'(sec_sel), 32'h1);
    trap(1'b1, 1'b0, 32'h170, 8'h00, 20'h8);
    trap(1'b1, 1'b1, 32'h1F6, 8'h00, 20'h2);
    trap(1'b1, 1'b1, 32'h176, 8'h00, 20'h8);
    pri_chan = '{native: 1'b1, cmd_base: 16'h1000, ctl_base: 16'h2000};
    sec_chan = '{native: 1'b1, cmd_base: 16'h3000, ctl_base: 16'h4000};
    trap(1'b1, 1'b0, 32'h1F0, 8'h00, 20'h0);
    trap(1'b1, 1'b0, 32'h1007, 8'h00, 20'h1);
    trap(1'b1, 1'b0, 32'h2002, 8'h00, 20'h1);
    trap(1'b1, 1'b0, 32'h376, 8'h00, 20'h0);
    trap(1'b1, 1'b0, 32'h3000, 8'h00, 20'h4);
    pri_chan = '0;
    sec_chan = '0;
    $display("test fixed decode done");
    for (int i = 0; i < 11; i++) begin
      ext_hit = 11'h1 << i;
      trap(1'b0, 1'b0, 32'h0, 8'h00, 20'h1 << (i < 3 ? 6 + i : (i < 5 ? 8 + i : 9 + i)));
    end
    ext_hit = '1;
    repeat (3) @(negedge sys_clk);
    ext_hit = '0;
    rd(8'hA8, 32'h0);
    usb_transfer_done = 1'b1;
    @(negedge sys_clk);
    usb_transfer_done = 1'b0;
    rd(8'hA8, 32'h2000);
    acpi_interrupt_route_select = 1'b1;
    #1 check({30'h0, sci_req, smi_req}, 32'h2);
    wr(8'hAC, 32'hFFFFDFFF);
    check(32'(trap_event_flag), 32'h0);
    wr(8'hA8, 32'hFFFFDFFF);
    rd(8'hA8, 32'h2000);
    wr(8'hA8, 32'h2000);
    rd(8'hA8, 32'h0);
    acpi_interrupt_route_select = 1'b0;
    $display("test status and routing done");
    wr(8'hB0, 32'h00300400);
    rnd();
    v = {1'b1, lfsr_state[6:0]};
    idle_reload_value = v;
    idle_reload_write = 1'b1;
    @(negedge sys_clk);
    idle_reload_write = 1'b0;
    check(32'(idle_timer_count), 32'(v));
    repeat (300) @(negedge sys_clk);
    check(32'(idle_timer_count < v), 32'h1);
    host.access(1'b1, 1'b0, 32'h60, 8'h00);
    check(32'(idle_timer_count), 32'(v));
    repeat (300) @(negedge sys_clk);
    external_smi_status = 1'b1;
    repeat (600) @(negedge sys_clk);
    check(32'(idle_timer_count), 32'(v));
    external_smi_status = 1'b0;
    repeat (300) @(negedge sys_clk);
    bus_master_req = 4'h4;
    @(negedge sys_clk);
    check(32'(idle_timer_count), 32'(v));
    bus_master_req = 4'h0;
    idle_reload_value = 8'h02;
    idle_reload_write = 1'b1;
    @(negedge sys_clk);
    idle_reload_write = 1'b0;
    repeat (800) @(negedge sys_clk);
    check({23'h0, idle_expired, idle_timer_count}, 32'h100);
    $display("test inactivity timer done");
    close_out();
  end
endmodule
